// *** logic/sps_defines.vh ***
// Purpose: constants for the serial port status flag block
// Assumes: included by the block's design file only
// Notes:   status offsets are register indices; byte address = 4 * index
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// ----------------------------------------
// register indices and own byte addresses
// ----------------------------------------
`define SPS_IDX_STAT_A 8'hc3
`define SPS_IDX_STAT_B 8'hd3
`define SPS_IDX_STAT_C 8'he3
`define SPS_IDX_STAT_D 8'hf3
`define SPS_ADDR_MODE 10'h000
`define SPS_ADDR_ISTAT 10'h004
`define SPS_ADDR_IMASK 10'h008

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define SPS_BIT_RXF 7
`define SPS_BIT_ADR 6
`define SPS_BIT_OVR 5
`define SPS_BIT_TXF 3
`define SPS_BIT_BSY 2

// ----------------------------------------
// reset values and bus answers
// ----------------------------------------
`define SPS_MODE_RST 4'h0
`define SPS_IMASK_RST 8'h00
`define SPS_RESP_OKAY 2'b00
`define SPS_RESP_SLVERR 2'b10

`endif

// *** logic/sps_top.v ***
// Purpose: status flags and interrupt requests of four serial ports
// Assumes: serial core events arrive as one-cycle pulses on SYS_CLK
// Notes:   registers over AXI4-Lite; one write and one read at a time
//
// Implementation choice: the AXI4-Lite interface to the registers.
`include "sps_defines.vh"

module sps_top #(
  parameter N_PORTS = 4
) (
  input wire SYS_CLK, // system clock, 100 MHz
  input wire SYS_RST, // synchronous reset, active high
  input wire [9:0] S_AXI_AWADDR, // write address
  input wire S_AXI_AWVALID, // write address valid
  output reg S_AXI_AWREADY, // write address ready
  input wire [31:0] S_AXI_WDATA, // write data
  input wire [3:0] S_AXI_WSTRB, // write byte enables
  input wire S_AXI_WVALID, // write data valid
  output reg S_AXI_WREADY, // write data ready
  output reg [1:0] S_AXI_BRESP, // write response
  output reg S_AXI_BVALID, // write response valid
  input wire S_AXI_BREADY, // write response ready
  input wire [9:0] S_AXI_ARADDR, // read address
  input wire S_AXI_ARVALID, // read address valid
  output reg S_AXI_ARREADY, // read address ready
  output reg [31:0] S_AXI_RDATA, // read data
  output reg [1:0] S_AXI_RRESP, // read response
  output reg S_AXI_RVALID, // read data valid
  input wire S_AXI_RREADY, // read data ready
  input wire [3:0] RX_LOAD, // byte enters receive buffer, pulse
  input wire [3:0] RX_ADDR_BIT, // address bit of that byte
  input wire [3:0] RX_READ, // receive buffer read, pulse
  input wire [3:0] RX_START, // start bit detected, pulse
  input wire [3:0] RX_SHIFT_FULL, // receive shifter holds a byte
  input wire [3:0] RX_OVERRUN, // clocked mode overrun, pulse
  input wire [3:0] TX_WRITE, // transmit buffer written, pulse
  input wire [3:0] TX_TAKE, // shifter takes byte, pulse
  input wire [3:0] TX_DONE, // stop bit or byte finished, pulse
  output reg [3:0] PORT_MODE, // per port: 1 clocked, 0 async
  output reg [3:0] RX_IRQ, // receive interrupt requests
  output reg [3:0] TX_IRQ, // transmit interrupt requests
  output reg IRQ // summary interrupt, level
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // byte address of a status register index
  function [9:0] idx_addr;
    input [7:0] idx;
    begin
      idx_addr = {idx, 2'b00};
    end
  endfunction
  // status decode: bit 2 hit, bits 1:0 port number
  function [2:0] stat_dec;
    input [9:0] addr;
    begin
      stat_dec = 3'h0;
      if (addr == idx_addr(`SPS_IDX_STAT_A))
        stat_dec = 3'h4;
      else if (addr == idx_addr(`SPS_IDX_STAT_B))
        stat_dec = 3'h5;
      else if (addr == idx_addr(`SPS_IDX_STAT_C))
        stat_dec = 3'h6;
      else if (addr == idx_addr(`SPS_IDX_STAT_D))
        stat_dec = 3'h7;
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [3:0] rxf_ff; // receive buffer full
  reg [3:0] adr_ff; // buffered byte had address bit
  reg [3:0] ovr_ff; // receive overrun
  reg [3:0] txf_ff; // transmit buffer full
  reg [3:0] bsy_ff; // transmitter busy
  reg [3:0] nxt_rxf;
  reg [3:0] nxt_adr;
  reg [3:0] nxt_ovr;
  reg [3:0] nxt_txf;
  reg [3:0] nxt_bsy;
  reg [3:0] nxt_rxirq;
  reg [3:0] nxt_txirq;
  reg [7:0] istat_ff; // sticky events, tx high nibble
  reg [7:0] imask_ff; // interrupt mask, same layout
  reg [7:0] nxt_istat;
  reg [3:0] ovr_evt; // overrun cause per port
  reg [3:0] bsy_fall; // busy ends this cycle
  reg [3:0] tx_set; // transmit interrupt cause
  reg [3:0] stat_wr; // status write strobe per port

  // write channel capture
  reg aw_got_ff; // address held
  reg w_got_ff; // data held
  reg [9:0] awaddr_ff; // held address
  reg [31:0] wdata_ff; // held data
  reg [3:0] wstrb_ff; // held strobes
  reg nxt_aw_got;
  reg nxt_w_got;
  reg nxt_bvalid;
  reg nxt_rvalid;
  wire wr_do; // register write happens this cycle
  wire rd_do; // read address taken this cycle
  wire [2:0] wr_dec; // status decode of write address
  wire [2:0] rd_dec; // status decode of read address
  reg wr_ok; // write address is mapped
  reg rd_ok; // read address is mapped
  reg [31:0] rd_val; // read data mux
  integer i;

  assign wr_do = aw_got_ff & w_got_ff & ~S_AXI_BVALID;
  assign rd_do = S_AXI_ARVALID & S_AXI_ARREADY;
  assign wr_dec = stat_dec(awaddr_ff);
  assign rd_dec = stat_dec(S_AXI_ARADDR);

  // ----------------------------------------
  // status write strobes
  // ----------------------------------------
  // any data value is ignored; only the access itself counts
  always @*
  begin
    stat_wr = 4'h0;
    if (wr_do && wr_dec[2])
      stat_wr[wr_dec[1:0]] = 1'b1;
  end

  // ----------------------------------------
  // flag next-state logic
  // ----------------------------------------
  // a set in the same cycle as a clear always wins
  always @*
  begin
    for (i = 0; i < N_PORTS; i = i + 1)
    begin
      // receive full: buffer loaded by core, emptied by a read
      nxt_rxf[i] = rxf_ff[i];
      if (RX_READ[i])
        nxt_rxf[i] = 1'b0;
      if (RX_LOAD[i])
        nxt_rxf[i] = 1'b1;
      // address bit travels with the buffered byte
      nxt_adr[i] = adr_ff[i];
      if (RX_LOAD[i])
        nxt_adr[i] = RX_ADDR_BIT[i];
      else if (RX_READ[i])
        nxt_adr[i] = 1'b0;
      // overrun cause depends on mode
      if (PORT_MODE[i])
        ovr_evt[i] = RX_OVERRUN[i];
      else
        ovr_evt[i] = RX_START[i] & RX_SHIFT_FULL[i] & rxf_ff[i];
      nxt_ovr[i] = ovr_ff[i];
      if (RX_READ[i])
        nxt_ovr[i] = 1'b0;
      if (ovr_evt[i])
        nxt_ovr[i] = 1'b1;
      // transmit full: cleared by take or by a status write
      nxt_txf[i] = txf_ff[i];
      if (TX_TAKE[i] || stat_wr[i])
        nxt_txf[i] = 1'b0;
      if (TX_WRITE[i])
        nxt_txf[i] = 1'b1;
      // busy ends at the stop bit; clocked mode only when starved
      bsy_fall[i] = bsy_ff[i] & TX_DONE[i] & ~TX_TAKE[i]
                    & (~PORT_MODE[i] | ~txf_ff[i]);
      nxt_bsy[i] = bsy_ff[i];
      if (bsy_fall[i])
        nxt_bsy[i] = 1'b0;
      if (TX_TAKE[i])
        nxt_bsy[i] = 1'b1;
      // receive interrupt: latch in async, level in clocked
      if (PORT_MODE[i])
        nxt_rxirq[i] = nxt_rxf[i];
      else
      begin
        nxt_rxirq[i] = RX_IRQ[i];
        if (RX_READ[i])
          nxt_rxirq[i] = 1'b0;
        if (RX_LOAD[i])
          nxt_rxirq[i] = 1'b1;
      end
      // transmit interrupt cause
      if (PORT_MODE[i])
        tx_set[i] = TX_TAKE[i] | bsy_fall[i];
      else
        tx_set[i] = bsy_fall[i] & ~txf_ff[i] & ~TX_WRITE[i];
      nxt_txirq[i] = TX_IRQ[i];
      if (TX_WRITE[i] || stat_wr[i])
        nxt_txirq[i] = 1'b0;
      if (tx_set[i])
        nxt_txirq[i] = 1'b1;
    end
  end

  // ----------------------------------------
  // flag registers
  // ----------------------------------------
  // flags and request outputs
  always @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      rxf_ff <= 4'h0;
      adr_ff <= 4'h0;
      ovr_ff <= 4'h0;
      txf_ff <= 4'h0;
      bsy_ff <= 4'h0;
      RX_IRQ <= 4'h0;
      TX_IRQ <= 4'h0;
    end
    else
    begin
      rxf_ff <= nxt_rxf;
      adr_ff <= nxt_adr;
      ovr_ff <= nxt_ovr;
      txf_ff <= nxt_txf;
      bsy_ff <= nxt_bsy;
      RX_IRQ <= nxt_rxirq;
      TX_IRQ <= nxt_txirq;
    end
  end

  // ----------------------------------------
  // interrupt status, mask and summary
  // ----------------------------------------
  // rising requests set sticky bits; write one clears, set wins
  always @*
  begin
    nxt_istat = istat_ff;
    if (wr_do && awaddr_ff == `SPS_ADDR_ISTAT && wstrb_ff[0])
      nxt_istat = nxt_istat & ~wdata_ff[7:0];
    nxt_istat = nxt_istat | {nxt_txirq & ~TX_IRQ, nxt_rxirq & ~RX_IRQ};
  end
  // software registers; summary output registered for a clean level
  always @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      istat_ff <= 8'h00;
      imask_ff <= `SPS_IMASK_RST;
      PORT_MODE <= `SPS_MODE_RST;
      IRQ <= 1'b0;
    end
    else
    begin
      istat_ff <= nxt_istat;
      if (wr_do && awaddr_ff == `SPS_ADDR_IMASK && wstrb_ff[0])
        imask_ff <= wdata_ff[7:0];
      if (wr_do && awaddr_ff == `SPS_ADDR_MODE && wstrb_ff[0])
        PORT_MODE <= wdata_ff[3:0];
      IRQ <= |(nxt_istat & imask_ff);
    end
  end

  // ----------------------------------------
  // read data mux
  // ----------------------------------------
  // status layout per active mode; unused bits stay zero
  always @*
  begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rd_dec[2])
    begin
      // bits 4, 1 and 0 never set in either mode
      rd_val[`SPS_BIT_RXF] = rxf_ff[rd_dec[1:0]];
      rd_val[`SPS_BIT_OVR] = ovr_ff[rd_dec[1:0]];
      rd_val[`SPS_BIT_TXF] = txf_ff[rd_dec[1:0]];
      rd_val[`SPS_BIT_BSY] = bsy_ff[rd_dec[1:0]];
      // address bit shown only in async mode
      if (!PORT_MODE[rd_dec[1:0]])
        rd_val[`SPS_BIT_ADR] = adr_ff[rd_dec[1:0]];
    end
    else if (S_AXI_ARADDR == `SPS_ADDR_MODE)
      rd_val[3:0] = PORT_MODE;
    else if (S_AXI_ARADDR == `SPS_ADDR_ISTAT)
      rd_val[7:0] = istat_ff;
    else if (S_AXI_ARADDR == `SPS_ADDR_IMASK)
      rd_val[7:0] = imask_ff;
    else
      rd_ok = 1'b0;
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // address and data taken in either order, answer after both
  always @*
  begin
    wr_ok = wr_dec[2] || awaddr_ff == `SPS_ADDR_MODE ||
            awaddr_ff == `SPS_ADDR_ISTAT || awaddr_ff == `SPS_ADDR_IMASK;
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_bvalid = S_AXI_BVALID;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
      nxt_aw_got = 1'b1;
    if (S_AXI_WVALID && S_AXI_WREADY)
      nxt_w_got = 1'b1;
    if (S_AXI_BVALID && S_AXI_BREADY)
      nxt_bvalid = 1'b0;
    if (wr_do)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
    end
  end

  // holding registers and handshake outputs
  always @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 10'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `SPS_RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
        awaddr_ff <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      // ready only while nothing of that channel is held
      S_AXI_AWREADY <= ~nxt_aw_got & ~nxt_bvalid;
      S_AXI_WREADY <= ~nxt_w_got & ~nxt_bvalid;
      S_AXI_BVALID <= nxt_bvalid;
      if (wr_do)
        S_AXI_BRESP <= wr_ok ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  // data captured in the cycle the address is taken
  always @*
  begin
    nxt_rvalid = S_AXI_RVALID;
    if (S_AXI_RVALID && S_AXI_RREADY)
      nxt_rvalid = 1'b0;
    if (rd_do)
      nxt_rvalid = 1'b1;
  end

  // reads have no side effects on any flag
  always @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `SPS_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= ~nxt_rvalid;
      S_AXI_RVALID <= nxt_rvalid;
      if (rd_do)
      begin
        S_AXI_RDATA <= rd_val;
        S_AXI_RRESP <= rd_ok ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
      end
    end
  end
endmodule

// *** dv/sps_top_assertions.sv ***
// Purpose: port-level checks of the serial status flag block
// Assumes: bound to sps_top; port 0 is watched for flag timing
// Notes:   shadow flags cannot see status writes, so they only narrow checks
module sps_top_assertions #(
  parameter N_PORTS = 4
) (
  input wire SYS_CLK, // system clock
  input wire SYS_RST, // sync reset, high
  input wire S_AXI_AWREADY, // write address ready
  input wire S_AXI_WREADY, // write data ready
  input wire S_AXI_BVALID, // write response valid
  input wire S_AXI_BREADY, // write response ready
  input wire S_AXI_ARVALID, // read address valid
  input wire S_AXI_ARREADY, // read address ready
  input wire S_AXI_RVALID, // read data valid
  input wire [3:0] RX_LOAD, // byte loaded
  input wire [3:0] RX_READ, // buffer read
  input wire [3:0] TX_WRITE, // tx buffer write
  input wire [3:0] TX_TAKE, // shifter take
  input wire [3:0] TX_DONE, // byte finished
  input wire [3:0] PORT_MODE, // 1 clocked
  input wire [3:0] RX_IRQ, // rx requests
  input wire [3:0] TX_IRQ // tx requests
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  reg busy_ff; // shadow of port 0 busy
  reg txf_ff; // shadow of port 0 tx full, may stay high too long
  // shadow flags from event pins only
  always @(posedge SYS_CLK)
  begin
    busy_ff <= !SYS_RST && (TX_TAKE[0] || (busy_ff && !TX_DONE[0]));
    txf_ff <= !SYS_RST && (TX_WRITE[0] || (txf_ff && !TX_TAKE[0]));
  end
  sequence s_tx_end;
    !PORT_MODE[0] && busy_ff && TX_DONE[0] && !TX_TAKE[0] && !TX_WRITE[0] && !txf_ff;
  endsequence
  sequence s_ar_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  chk_rx_set: assert property (!PORT_MODE[0] && RX_LOAD[0] |=> RX_IRQ[0])
    else $error("rx request missing after load");
  chk_rx_clear: assert property (RX_READ[0] && !RX_LOAD[0] |=> !RX_IRQ[0])
    else $error("rx request kept after read");
  chk_clk_rx_hold: assert property (PORT_MODE[0] && RX_LOAD[0] |=>
    RX_IRQ[0] ##1 (RX_IRQ[0] || $past(RX_READ[0])))
    else $error("clocked rx request dropped while full");
  chk_tx_take_irq: assert property (PORT_MODE[0] && TX_TAKE[0] |=> TX_IRQ[0])
    else $error("clocked tx request missing on take");
  chk_tx_wr_clear: assert property (PORT_MODE[0] && TX_WRITE[0] && !TX_TAKE[0]
    && !TX_DONE[0] |=> !TX_IRQ[0])
    else $error("clocked tx request kept after write");
  chk_tx_idle_irq: assert property (s_tx_end |=> TX_IRQ[0])
    else $error("async tx request missing at idle");
  chk_rd_answer: assert property (s_ar_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer not in next cycle");
  chk_b_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response held after handshake");
  chk_w_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while response pending");
endmodule
bind sps_top sps_top_assertions #(.N_PORTS(N_PORTS)) u_sps_top_assertions (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .RX_LOAD(RX_LOAD), .RX_READ(RX_READ), .TX_WRITE(TX_WRITE), .TX_TAKE(TX_TAKE),
  .TX_DONE(TX_DONE), .PORT_MODE(PORT_MODE), .RX_IRQ(RX_IRQ), .TX_IRQ(TX_IRQ)
);

// *** dv/sps_line_model.sv ***
// Purpose: serial core and line side model driving the event pins
// Assumes: each call starts after a rising edge
// Notes:   groups: 0 load 1 addr 2 read 3 start 4 shift 5 ovr 6 write 7 take 8 done
module sps_line_model (
  input logic clk, // system clock
  output logic [35:0] ev // nine 4-bit event groups
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ev = '0;
  // one-cycle pulse; the caller's spacing sets prompt or slow answers
  task automatic pulse(input int k, input logic [3:0] m);
    @(posedge clk);
    ev[k*4+:4] <= m;
    @(posedge clk);
    ev[k*4+:4] <= 4'h0;
  endtask
  // level group, held until changed
  task automatic level(input int k, input logic [3:0] m);
    @(posedge clk);
    ev[k*4+:4] <= m;
  endtask
endmodule

// *** dv/sps_top_tb_top.sv ***
// Purpose: self-checking bench of the serial status flag block
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes:   port 0 in depth; other ports read back idle
module sps_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready, irq;
  logic awready, wready, arready;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, mode, rxirq, txirq;
  logic [1:0] bresp, rresp, r;
  logic [35:0] ev; // event groups from the line model
  int err_count, cmp_count;
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  sps_top u_sps_top (
    .SYS_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .RX_LOAD(ev[3:0]), .RX_ADDR_BIT(ev[7:4]), .RX_READ(ev[11:8]), .RX_START(ev[15:12]),
    .RX_SHIFT_FULL(ev[19:16]), .RX_OVERRUN(ev[23:20]), .TX_WRITE(ev[27:24]),
    .TX_TAKE(ev[31:28]), .TX_DONE(ev[35:32]), .PORT_MODE(mode), .RX_IRQ(rxirq),
    .TX_IRQ(txirq), .IRQ(irq)
  );
  sps_line_model u_sps_line_model (.clk(clk), .ev(ev));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // a hung handshake counts as a mismatch and ends the run
  task automatic hang;
    err_count++;
    complete_run();
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] o);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // address and data are released separately as each is taken
    do
    begin
      @(posedge clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    o = bresp;
    bready <= 1'b0;
    if (n >= 100)
      hang();
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] o);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    v = rdata;
    o = rresp;
    rready <= 1'b0;
    if (n >= 100)
      hang();
  endtask
  // status read: low byte only, upper bits zero, OKAY answer
  task automatic st(input logic [9:0] a, input logic [7:0] e);
    rd(a, d, r);
    chk("status", d, {24'h0, e});
    chk("status resp", r, 2'b00);
  endtask
  task automatic p(input int k);
    u_sps_line_model.pulse(k, 4'h1);
  endtask
  task automatic test_async_rx;
    u_sps_line_model.level(1, 4'h1);
    p(0);
    st(10'h30c, 8'hc0);
    chk("rx irq", rxirq, 4'h1);
    u_sps_line_model.level(4, 4'h1);
    p(3);
    st(10'h30c, 8'he0);
    wr(10'h008, 32'h1, r);
    // summary output is registered one cycle behind the new mask
    @(posedge clk);
    chk("irq unmasked", irq, 1'b1);
    rd(10'h004, d, r);
    chk("istat rx rise", d, 32'h1);
    wr(10'h004, 32'h1, r);
    chk("irq cleared", irq, 1'b0);
    u_sps_line_model.level(1, 4'h0);
    u_sps_line_model.level(4, 4'h0);
    p(0);
    st(10'h30c, 8'ha0);
    p(2);
    st(10'h30c, 8'h00);
    chk("rx irq read", rxirq, 4'h0);
    $display("test_async_rx done");
  endtask
  task automatic test_async_tx;
    p(6);
    st(10'h30c, 8'h08);
    wr(10'h30c, 32'hffffffff, r);
    st(10'h30c, 8'h00);
    p(6);
    p(7);
    st(10'h30c, 8'h04);
    p(8);
    st(10'h30c, 8'h00);
    chk("tx irq idle", txirq, 4'h1);
    wr(10'h30c, 32'h0, r);
    chk("tx irq status wr", txirq, 4'h0);
    // busy ends while a byte still waits: no transmit request
    p(6);
    p(7);
    p(6);
    p(8);
    st(10'h30c, 8'h08);
    chk("tx irq byte waits", txirq, 4'h0);
    wr(10'h30c, 32'h0, r);
    st(10'h30c, 8'h00);
    $display("test_async_tx done");
  endtask
  task automatic test_clocked;
    wr(10'h000, 32'h1, r);
    chk("mode", mode, 4'h1);
    u_sps_line_model.level(1, 4'h1);
    p(0);
    st(10'h30c, 8'h80);
    chk("clk rx irq", rxirq, 4'h1);
    p(5);
    st(10'h30c, 8'ha0);
    p(2);
    st(10'h30c, 8'h00);
    chk("clk rx irq off", rxirq, 4'h0);
    p(6);
    p(7);
    st(10'h30c, 8'h04);
    chk("clk tx irq take", txirq, 4'h1);
    p(6);
    st(10'h30c, 8'h0c);
    chk("clk tx irq wr", txirq, 4'h0);
    p(8);
    st(10'h30c, 8'h0c);
    p(7);
    // drop the take request so only the starved end can raise it
    wr(10'h30c, 32'h0, r);
    chk("clk tx irq pre idle", txirq, 4'h0);
    p(8);
    st(10'h30c, 8'h00);
    chk("clk tx irq idle", txirq, 4'h1);
    wr(10'h30c, 32'h0, r);
    chk("clk tx irq st wr", txirq, 4'h0);
    wr(10'h000, 32'h0, r);
    $display("test_clocked done");
  endtask
  task automatic test_bus;
    rd(10'h100, d, r);
    chk("unmapped rresp", r, 2'b10);
    chk("unmapped rdata", d, 32'h0);
    wr(10'h100, 32'h1, r);
    chk("unmapped bresp", r, 2'b10);
    rd(10'h008, d, r);
    chk("mask readback", d, 32'h1);
    st(10'h34c, 8'h00);
    st(10'h38c, 8'h00);
    st(10'h3cc, 8'h00);
    $display("test_bus done");
  endtask
  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    test_async_rx();
    test_async_tx();
    test_clocked();
    test_bus();
    complete_run();
  end
endmodule
